// >>> dv/tcs_path_rx.sv
// Receiver model of the downstream VC-4 path
`timescale 1ns/10ps
`default_nettype none

module tcs_path_rx (
	input wire logic arst_n,
	input wire logic path_clock_out,
	input wire logic [7:0] path_data_out,
	input wire logic path_frame_start_out
);
	logic [8:0] rx_q[$];

	always @(posedge path_clock_out) begin
		if (arst_n) begin
			rx_q.push_back({path_frame_start_out, path_data_out});
		end
	end
endmodule : tcs_path_rx

`default_nettype wire

// >>> dv/tcs_source_tb.sv
// Self-checking bench for the tandem connection source
`timescale 1ns/10ps
`default_nettype none

module tcs_source_tb import tcs_pkg::*;;
	localparam int NFR = 5;
	localparam int FB = TCS_FRAME_BYTES;
	localparam int B3I = int'(TCS_B3_IDX);
	localparam int N1I = int'(TCS_N1_IDX);
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] din = 8'h00;
	logic ck_in = 1'b0;
	logic fs_in = 1'b0;
	logic sf = 1'b0;
	logic rdi = 1'b0;
	logic rei = 1'b0;
	logic odi = 1'b0;
	logic oei = 1'b0;
	logic [TCS_TRACE_BITS-1:0] tti = {16{8'ha5}};
	logic [7:0] pdo;
	logic pco;
	logic pfo;
	logic [8:0] in_q[$];
	int err_count = 0;
	int checks = 0;

	tcs_source DUT (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.adapted_data_in(din),
		.adapted_clock_in(ck_in),
		.adapted_frame_start_in(fs_in),
		.incoming_signal_fail(sf),
		.remote_defect_request(rdi),
		.remote_error_value(rei),
		.outgoing_defect_request(odi),
		.outgoing_error_value(oei),
		.transmit_trace_identifier(tti),
		.path_data_out(pdo),
		.path_clock_out(pco),
		.path_frame_start_out(pfo)
	);

	tcs_path_rx far (
		.arst_n(arst_n),
		.path_clock_out(pco),
		.path_data_out(pdo),
		.path_frame_start_out(pfo)
	);

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check8

	task automatic check1(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : check1

	// One byte on the link, 4 cycles low then 4 high
	task automatic send_byte(input logic [7:0] d, input logic fs);
		@(posedge clk_sys);
		#1;
		din = d;
		fs_in = fs;
		ck_in = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		ck_in = 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask : send_byte

	task automatic results();
		$display("Checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		logic [7:0] par;
		logic [7:0] prev_par;
		logic [7:0] d;
		logic [7:0] g;
		logic [7:0] e;
		logic [7:0] m;
		logic [7:0] errv[NFR];
		logic [3:0] iec[NFR];
		int f;
		int x;
		errv = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
		iec = '{4'h0, 4'h0, TCS_IEC_ZERO, 4'h8, TCS_IEC_FAIL};
		prev_par = 8'h00;
		repeat (3) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		for (f = 0; f < NFR; f++) begin
			par = 8'h00;
			for (x = 0; x < FB; x++) begin
				d = 8'(x * 13 + f * 7 + 3);
				if (x == B3I) begin
					d = prev_par ^ errv[f];
				end
				par ^= d;
				in_q.push_back({x == 0, d});
				send_byte(d, x == 0);
				if (x == 2200) begin
					#1;
					rei = 1'((f + 1) % 2);
					oei = 1'(((f + 1) / 2) % 2);
					rdi = rei;
					odi = oei;
					sf = (f + 1 == 4);
				end
			end
			prev_par = par;
		end
		repeat (100) @(posedge clk_sys);
		$display("Test stream done: %0d bytes sent", in_q.size());
		check1(far.rx_q.size() == in_q.size(), 1'b1, "byte count");
		for (x = 0; x < in_q.size() && x < far.rx_q.size(); x++) begin
			f = x / FB;
			check1(far.rx_q[x][8], in_q[x][8], "frame start");
			if (x % FB == B3I && f > 0) begin
				g = far.rx_q[x][7:0] ^ far.rx_q[x - FB][7:0] ^ far.rx_q[(f - 1) * FB + N1I][7:0];
				e = in_q[x][7:0] ^ in_q[x - FB][7:0] ^ in_q[(f - 1) * FB + N1I][7:0];
				check8(g, e, "b3 comp");
			end else if (x % FB == N1I) begin
				m = (f < 2) ? 8'h0f : 8'hff;
				e = {iec[f], 1'(f % 2), 1'((f / 2) % 2), TCS_ALIGN_PATTERN[15 - 2 * f -: 2]};
				check8(far.rx_q[x][7:0] & m, e & m, "n1");
			end else if (x % FB != B3I) begin
				check8(far.rx_q[x][7:0], in_q[x][7:0], "data");
			end
		end
		$display("Test compare done");
		results();
	end

	initial begin
		#2000000;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end
endmodule : tcs_source_tb

`default_nettype wire

// >>> hw/tcs_pkg.sv
// Constants for the tandem connection source
package tcs_pkg;
	localparam int unsigned TCS_FRAME_BYTES = 2349;
	localparam logic [11:0] TCS_B3_IDX = 12'h105;
	localparam logic [11:0] TCS_N1_IDX = 12'h828;
	localparam logic [11:0] TCS_CNT_MAX = 12'hfff;
	localparam logic [6:0] TCS_MF_FIRST = 7'h01;
	localparam logic [6:0] TCS_MF_LAST = 7'h4c;
	localparam logic [6:0] TCS_MF_ALIGN_END = 7'h08;
	localparam logic [6:0] TCS_MF_TRACE_END = 7'h48;
	localparam logic [6:0] TCS_MF_RDI = 7'h49;
	localparam logic [6:0] TCS_MF_ODI = 7'h4a;
	localparam logic [15:0] TCS_ALIGN_PATTERN = 16'hfffe;
	localparam logic [3:0] TCS_IEC_ZERO = 4'h9;
	localparam logic [3:0] TCS_IEC_FAIL = 4'he;
	localparam int unsigned TCS_TRACE_BITS = 128;
	localparam int unsigned TCS_FIFO_WIDTH = 9;
	localparam int unsigned TCS_FIFO_DEPTH = 8;
	localparam int unsigned TCS_CLK_MHZ = 50;
	localparam int unsigned TCS_OUT_HALF_NS = 60;
	localparam logic [2:0] TCS_OUT_HALF_CYC = 3'(TCS_OUT_HALF_NS * TCS_CLK_MHZ / 1000);
	typedef enum logic [1:0] {
		TCS_OUT_IDLE = 2'b00,
		TCS_OUT_LOW = 2'b01,
		TCS_OUT_HIGH = 2'b10
	} tcs_out_e;
endpackage : tcs_pkg

// >>> hw/tcs_source.sv
// Tandem connection trail termination source with output FIFO
`timescale 1ns/10ps
`default_nettype none

module tcs_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			if (pop) rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : tcs_fifo

// Functional notes
// - Send remote defect in frame 73 bit 8
// - Stop remote defect within one multiframe
// - Bits 7-8 form 76-frame multiframe
// - Remote error value into bit 5
// - Send outgoing defect in frame 74 bit 7
// - Stop outgoing defect at first chance
// - Outgoing error value into bit 6
// - Frames 1-8 carry alignment pattern
// - Frames 9-72 carry management trace identifier
// - Reserved bits in frames 73-76 zero
// - Count parity violations against previous frame
// - Violation count 1-8 as binary code
// - Zero violations coded as 1001
// - Signal fail writes code 1110
// - Compensate B3 for rewritten N1
module tcs_source import tcs_pkg::*; (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] adapted_data_in,
	input wire logic adapted_clock_in,
	input wire logic adapted_frame_start_in,
	input wire logic incoming_signal_fail,
	input wire logic remote_defect_request,
	input wire logic remote_error_value,
	input wire logic outgoing_defect_request,
	input wire logic outgoing_error_value,
	input wire logic [TCS_TRACE_BITS-1:0] transmit_trace_identifier,
	output logic [7:0] path_data_out,
	output logic path_clock_out,
	output logic path_frame_start_out
);
	function automatic logic [3:0] tcs_popcount(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + 4'(v[i]);
		end
		return n;
	endfunction : tcs_popcount

	function automatic logic [1:0] tcs_mf_bits(input logic [6:0] mf,
		input logic [TCS_TRACE_BITS-1:0] tti, input logic rdi, input logic odi);
		logic [7:0] k;
		k = 8'h00;
		if (mf <= TCS_MF_ALIGN_END) begin
			k = 8'({mf - 7'h01, 1'b0});
			return {TCS_ALIGN_PATTERN[4'hf - k[3:0]], TCS_ALIGN_PATTERN[4'he - k[3:0]]};
		end else if (mf <= TCS_MF_TRACE_END) begin
			k = 8'({mf - (TCS_MF_ALIGN_END + 7'h01), 1'b0});
			return {tti[7'h7f - k[6:0]], tti[7'h7e - k[6:0]]};
		end else if (mf == TCS_MF_RDI) begin
			return {1'b0, rdi};
		end else if (mf == TCS_MF_ODI) begin
			return {odi, 1'b0};
		end else begin
			return 2'b00;
		end
	endfunction : tcs_mf_bits

	// Pin synchronisers, two stages each
	logic [10:0] sync1_reg;
	logic [10:0] sync2_reg;
	logic [3:0] ctl1_reg;
	logic [3:0] ctl2_reg;
	logic ck_last_reg;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			ctl1_reg <= '0;
			ctl2_reg <= '0;
			ck_last_reg <= 1'b0;
		end else begin
			sync1_reg <= {adapted_clock_in, adapted_frame_start_in, incoming_signal_fail,
				adapted_data_in};
			sync2_reg <= sync1_reg;
			ctl1_reg <= {remote_defect_request, remote_error_value, outgoing_defect_request,
				outgoing_error_value};
			ctl2_reg <= ctl1_reg;
			ck_last_reg <= sync2_reg[10];
		end
	end
	wire [7:0] data_s = sync2_reg[7:0];
	wire sf_s = sync2_reg[8];
	wire fs_s = sync2_reg[9];
	wire rdi_s = ctl2_reg[3];
	wire rei_s = ctl2_reg[2];
	wire odi_s = ctl2_reg[1];
	wire oei_s = ctl2_reg[0];
	wire byte_ev = sync2_reg[10] & ~ck_last_reg;

	// Frame state and stage toward the FIFO
	logic [11:0] cnt_reg;
	logic [6:0] mf_reg;
	logic [7:0] bip_acc_reg;
	logic [7:0] bip_prev_reg;
	logic [3:0] viol_reg;
	logic rei_lat_reg;
	logic oei_lat_reg;
	logic [7:0] b3_in_reg;
	logic [7:0] b3_out_reg;
	logic [7:0] n1_in_reg;
	logic [7:0] n1_out_reg;
	logic stg_vld_reg;
	logic [8:0] stg_data_reg;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [8:0] fifo_out_data;
	logic out_take;

	wire proc_go = byte_ev & (~stg_vld_reg | fifo_in_ready);
	wire [11:0] cnt_now = fs_s ? 12'h000 : cnt_reg;
	wire is_b3 = (cnt_now == TCS_B3_IDX);
	wire is_n1 = (cnt_now == TCS_N1_IDX);
	wire [7:0] bip_diff = bip_prev_reg ^ data_s;
	wire [3:0] viol_now = tcs_popcount(bip_diff);
	// binary count, zero coded, fail code
	wire [3:0] iec_code = sf_s ? TCS_IEC_FAIL : (viol_reg == 4'h0) ? TCS_IEC_ZERO : viol_reg;
	// alignment, trace, remote defect, outgoing defect, zeros
	wire [1:0] mf_bits = tcs_mf_bits(mf_reg, transmit_trace_identifier, rdi_s, odi_s);
	// remote error bit, outgoing error bit
	wire [7:0] n1_new = {iec_code, rei_lat_reg, oei_lat_reg, mf_bits};
	wire [7:0] b3_new = data_s ^ b3_in_reg ^ b3_out_reg ^ n1_in_reg ^ n1_out_reg;
	wire [7:0] byte_out = is_n1 ? n1_new : is_b3 ? b3_new : data_s;
	wire [6:0] mf_next = (mf_reg == TCS_MF_LAST) ? TCS_MF_FIRST : mf_reg + 7'h01;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			mf_reg <= TCS_MF_FIRST;
			bip_acc_reg <= '0;
			bip_prev_reg <= '0;
			viol_reg <= '0;
			rei_lat_reg <= 1'b0;
			oei_lat_reg <= 1'b0;
			b3_in_reg <= '0;
			b3_out_reg <= '0;
			n1_in_reg <= '0;
			n1_out_reg <= '0;
		end else if (proc_go) begin
			cnt_reg <= (cnt_now == TCS_CNT_MAX) ? cnt_now : cnt_now + 12'h001;
			bip_acc_reg <= fs_s ? data_s : bip_acc_reg ^ data_s;
			if (fs_s) begin
				bip_prev_reg <= bip_acc_reg;
				rei_lat_reg <= rei_s;
				oei_lat_reg <= oei_s;
			end
			if (is_b3) begin
				viol_reg <= viol_now;
				b3_in_reg <= data_s;
				b3_out_reg <= b3_new;
			end
			if (is_n1) begin
				n1_in_reg <= data_s;
				n1_out_reg <= n1_new;
				mf_reg <= mf_next;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stg_vld_reg <= 1'b0;
			stg_data_reg <= '0;
		end else if (proc_go) begin
			stg_vld_reg <= 1'b1;
			stg_data_reg <= {fs_s, byte_out};
		end else if (fifo_in_ready) begin
			stg_vld_reg <= 1'b0;
		end
	end

	tcs_fifo #(
		.WIDTH(TCS_FIFO_WIDTH),
		.DEPTH(TCS_FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.in_valid(stg_vld_reg),
		.in_ready(fifo_in_ready),
		.in_data(stg_data_reg),
		.out_valid(fifo_out_valid),
		.out_ready(out_take),
		.out_data(fifo_out_data)
	);

	// Output clock generator, data changes with the falling edge
	tcs_out_e ost_reg;
	logic [2:0] half_reg;
	wire half_done = (half_reg == TCS_OUT_HALF_CYC - 3'h1);
	assign out_take = fifo_out_valid & ((ost_reg == TCS_OUT_IDLE) |
		((ost_reg == TCS_OUT_HIGH) & half_done));
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ost_reg <= TCS_OUT_IDLE;
			half_reg <= '0;
			path_data_out <= '0;
			path_frame_start_out <= 1'b0;
			path_clock_out <= 1'b0;
		end else begin
			half_reg <= (out_take | half_done) ? 3'h0 : half_reg + 3'h1;
			if (out_take) begin
				ost_reg <= TCS_OUT_LOW;
				path_data_out <= fifo_out_data[7:0];
				path_frame_start_out <= fifo_out_data[8];
				path_clock_out <= 1'b0;
			end else begin
				case (ost_reg)
					TCS_OUT_LOW: begin
						if (half_done) begin
							ost_reg <= TCS_OUT_HIGH;
							path_clock_out <= 1'b1;
						end
					end
					TCS_OUT_HIGH: begin
						if (half_done) begin
							ost_reg <= TCS_OUT_IDLE;
						end
					end
					default: begin
						ost_reg <= TCS_OUT_IDLE;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_IEC_FAIL: assert property (proc_go && is_n1 && sf_s |=> stg_data_reg[7:4] == 4'he)
		else $error("signal fail code not written");
	AST_IEC_ZERO: assert property (proc_go && is_n1 && !sf_s && viol_reg == 4'h0
		|=> stg_data_reg[7:4] == 4'h9) else $error("zero violations not coded 1001");
	AST_IEC_COUNT: assert property (proc_go && is_n1 && !sf_s && viol_reg != 4'h0
		|=> stg_data_reg[7:4] == $past(viol_reg)) else $error("violation count wrong");
	AST_VIOL_CNT: assert property (proc_go && is_b3 && bip_diff == 8'hff
		|=> viol_reg == 4'h8) else $error("violation count not eight");
	AST_ERR_BITS: assert property (proc_go && is_n1
		|=> stg_data_reg[3:2] == $past({rei_lat_reg, oei_lat_reg}))
		else $error("error bits not copied");
	AST_ALIGN: assert property (proc_go && is_n1 && mf_reg == 7'h08
		|=> stg_data_reg[1:0] == 2'b10) else $error("alignment end wrong");
	AST_RDI: assert property (proc_go && is_n1 && mf_reg == 7'h49
		|=> stg_data_reg[1:0] == {1'b0, $past(rdi_s)}) else $error("remote defect bit wrong");
	AST_ODI: assert property (proc_go && is_n1 && mf_reg == 7'h4a
		|=> stg_data_reg[1:0] == {$past(odi_s), 1'b0}) else $error("outgoing defect bit wrong");
	AST_RSVD: assert property (proc_go && is_n1 && mf_reg > 7'h4a
		|=> stg_data_reg[1:0] == 2'b00) else $error("reserved bits not zero");
	AST_MF_WRAP: assert property (proc_go && is_n1 && mf_reg == 7'h4c
		|=> mf_reg == 7'h01) else $error("multiframe did not wrap");
	AST_PASS: assert property (proc_go && !is_n1 && !is_b3
		|=> stg_data_reg == $past({fs_s, data_s})) else $error("byte altered");
	AST_B3: assert property (proc_go && is_b3
		|=> stg_data_reg[7:0] == ($past(data_s) ^ $past(b3_in_reg) ^ $past(b3_out_reg)
		^ $past(n1_in_reg) ^ $past(n1_out_reg))) else $error("B3 compensation wrong");
endmodule : tcs_source

`default_nettype wire
